// [hdl/rot_refresh_top.v]
// Rotated LCD refresh sequencer with AXI4-Lite registers
// Summary of operation
// - Active line width is (field+1) times 8 pixels.
// - Line blanking is (field+4) times 8 pixels.
// - Active lines are one plus 10-bit value from two fields.
// - Vertical blanking lines equal the 6-bit field, no offset.
// - Single panel frame is line total times line count in pixel clocks.
// - Inversion is applied after the look-up table.
// - Monochrome bit, at any depth, uses only the green table entry.
// - Rotate bit set, select clear: default; both set: alternate.
// - Rotated scan starts top right, runs down columns, moves left.
// - Rotated frame fetch begins at the programmed start address.
// - Successive pixels of a rotated line step by line byte count.
// - Start address plus one pans horizontally one byte.
// - Default mode pans vertically two lines per twice stride.
// - Alternate mode pans vertically one line per stride added.
// - Line byte count zero means 256, else exactly that many.
// - Rotated pixel clock divide 1,2,4,8 from select, but 2 for select 0 in alternate mode; none landscape.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lcd_rot_defs.vh"
module rot_refresh_top #(
  parameter AW = 17
) (
  input wire CLK,
  input wire RSTN,
  input wire [31:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [31:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  output reg [AW-1:0] MEM_ADDR,
  output reg MEM_RD,
  input wire [7:0] MEM_DATA,
  output reg PCLK_EN,
  output reg LINE_START,
  output reg FRAME_START,
  output reg [11:0] PIX_DATA,
  output reg PIX_VALID
);
  reg [31:0] ctrl_q, htim_q, vtim_q, start_q, stride_q, lut_q;
  reg [4:0] awa_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg aw_have_q, w_have_q;
  reg [11:0] hcnt_q;
  reg [10:0] vcnt_q;
  reg [7:0] frames_q;
  reg [2:0] div_q;
  reg [AW-1:0] addr_q, base_q;
  reg [2:0] lsub_q, psub_q, sh_q, sh2_q;
  reg s2_v_q, s3_v_q;
  wire [11:0] lut_rd;

  ////////////////////////////////////////////////////////////////////////
  // Register fields and derived timing
  wire [1:0] psel = ctrl_q[`CTRL_PSEL_LO+1:`CTRL_PSEL_LO];
  wire rot = ctrl_q[`CTRL_ROT];
  wire alt = rot & ctrl_q[`CTRL_ALT];
  wire invert = ctrl_q[`CTRL_INV];
  wire mono = ctrl_q[`CTRL_MONO];
  wire [1:0] bsel = ctrl_q[`CTRL_BPP_LO+1:`CTRL_BPP_LO];
  wire dual = ctrl_q[`CTRL_DUAL];
  wire en = ctrl_q[`CTRL_EN];
  wire [6:0] hact_f = htim_q[`HT_ACT_LO+6:`HT_ACT_LO];
  wire [4:0] hblk_f = htim_q[`HT_BLK_LO+4:`HT_BLK_LO];
  wire [9:0] vact_f = {vtim_q[`VT_ACT_HI+1:`VT_ACT_HI],
                       vtim_q[`VT_ACT_LO+7:`VT_ACT_LO]};
  wire [5:0] vblk_f = vtim_q[`VT_BLK_LO+5:`VT_BLK_LO];
  wire [10:0] horiz_active_period = {({1'b0, hact_f} + `H_ACT_ONE), 3'b000};
  wire [8:0] hnd = {({1'b0, hblk_f} + `H_BLK_ADD), 3'b000};
  wire [11:0] htot = {1'b0, horiz_active_period} + {3'b000, hnd};
  wire [10:0] vert_active_period = {1'b0, vact_f} + `V_ACT_ONE;
  wire [10:0] vnd = {5'b00000, vblk_f};
  wire [11:0] hlen = dual ? {htot[10:0], 1'b0} : htot;
  wire [10:0] vact_n = dual ? {1'b0, vert_active_period[10:1]} : vert_active_period;
  wire [10:0] vtot = vact_n + vnd;
  wire [22:0] frame_len = hlen * vtot;
  wire [8:0] stride = (stride_q[7:0] == 8'h00) ? `STRIDE_ZERO :
                      {1'b0, stride_q[7:0]};
  wire [2:0] ppb_m1 = (3'b111 >> bsel);
  wire [7:0] pmask = (8'h01 << (4'h1 << bsel)) - 8'h01;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  wire aw_take = AWVALID & AWREADY;
  wire w_take = WVALID & WREADY;
  wire ar_take = ARVALID & ARREADY;
  wire do_write = aw_have_q & w_have_q;
  wire aw_have_d = (aw_have_q | aw_take) & ~do_write;
  wire w_have_d = (w_have_q | w_take) & ~do_write;
  wire bvalid_d = (BVALID & ~BREADY) | do_write;
  wire rvalid_d = (RVALID & ~RREADY) | ar_take;
  wire [31:0] wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}},
                       {8{ws_q[0]}}};

  function [32:0] rd_word;
    input [4:0] a;
    begin
      case (a)
        `OFS_CTRL: rd_word = {1'b1, ctrl_q};
        `OFS_HTIME: rd_word = {1'b1, htim_q};
        `OFS_VTIME: rd_word = {1'b1, vtim_q};
        `OFS_START: rd_word = {1'b1, start_q};
        `OFS_STRIDE: rd_word = {1'b1, stride_q};
        `OFS_LUT: rd_word = {1'b1, lut_q};
        `OFS_STATUS: rd_word = {1'b1, frames_q, 5'h00, alt, rot,
                                (vcnt_q >= vact_n), 5'h00, vcnt_q};
        `OFS_FLEN: rd_word = {1'b1, 9'h000, frame_len};
        default: rd_word = {1'b0, `RST_WORD};
      endcase
    end
  endfunction

  wire [32:0] wr_old = rd_word(awa_q);
  wire [32:0] rd_cur = rd_word(ARADDR[4:0]);
  wire wr_ok = wr_old[32];
  wire [31:0] merged = (wr_old[31:0] & ~wmask) | (wd_q & wmask);
  wire wr_lut = do_write & (awa_q == `OFS_LUT);

  always @(posedge CLK) begin
    if (!RSTN) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `RESP_OKAY;
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= `RST_WORD;
      RRESP <= `RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awa_q <= 5'h00;
      wd_q <= `RST_WORD;
      ws_q <= 4'h0;
      ctrl_q <= `RST_WORD;
      htim_q <= `RST_WORD;
      vtim_q <= `RST_WORD;
      start_q <= `RST_WORD;
      stride_q <= `RST_WORD;
      lut_q <= `RST_WORD;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      AWREADY <= ~aw_have_d & ~bvalid_d;
      WREADY <= ~w_have_d & ~bvalid_d;
      BVALID <= bvalid_d;
      RVALID <= rvalid_d;
      ARREADY <= ~rvalid_d;
      if (aw_take) begin
        awa_q <= {AWADDR[4:2], 2'b00};
      end
      if (w_take) begin
        wd_q <= WDATA;
        ws_q <= WSTRB;
      end
      if (ar_take) begin
        RDATA <= (ARADDR[1:0] == 2'b00) ? rd_cur[31:0] : `RST_WORD;
        RRESP <= (rd_cur[32] & (ARADDR[1:0] == 2'b00)) ? `RESP_OKAY :
                 `RESP_SLVERR;
      end
      if (do_write) begin
        BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        case (awa_q)
          `OFS_CTRL: ctrl_q <= merged & `MASK_CTRL;
          `OFS_HTIME: htim_q <= merged & `MASK_HTIME;
          `OFS_VTIME: vtim_q <= merged & `MASK_VTIME;
          `OFS_START: start_q <= merged & `MASK_START;
          `OFS_STRIDE: stride_q <= merged & `MASK_STRIDE;
          `OFS_LUT: lut_q <= merged & `MASK_LUT;
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel clock enable divider
  reg [1:0] dsel;
  always @* begin
    dsel = 2'b00;
    if (rot) begin
      dsel = psel;
      if (alt && psel == 2'b00) begin
        dsel = 2'b01;
      end
    end
  end
  wire [2:0] div_lim = (3'b001 << dsel) - 3'b001;
  wire tick = en & (div_q == 3'b000);

  ////////////////////////////////////////////////////////////////////////
  // Raster counters and buffer scan
  wire [11:0] hdp_x = {1'b0, horiz_active_period};
  wire h_act = (hcnt_q < hdp_x) |
               (dual & (hcnt_q >= htot) & (hcnt_q < htot + hdp_x));
  wire act = h_act & (vcnt_q < vact_n);
  wire line_end = (hcnt_q == hlen - 12'h001);
  wire frame_end = line_end & (vcnt_q == vtot - 11'h001);
  wire [5:0] rsh = {3'b000, lsub_q} << bsel;
  wire [5:0] lsh = {3'b000, ppb_m1 - psub_q} << bsel;
  wire [AW-1:0] stride_x = {{(AW-9){1'b0}}, stride};
  wire [AW-1:0] base_m1 = base_q - {{(AW-1){1'b0}}, 1'b1};

  always @(posedge CLK) begin
    if (!RSTN) begin
      div_q <= 3'b000;
      hcnt_q <= 12'h000;
      vcnt_q <= 11'h000;
      frames_q <= 8'h00;
      addr_q <= {AW{1'b0}};
      base_q <= {AW{1'b0}};
      lsub_q <= 3'b000;
      psub_q <= 3'b000;
      sh_q <= 3'b000;
      MEM_ADDR <= {AW{1'b0}};
      MEM_RD <= 1'b0;
      PCLK_EN <= 1'b0;
      LINE_START <= 1'b0;
      FRAME_START <= 1'b0;
    end else begin
      PCLK_EN <= tick;
      MEM_RD <= tick & act;
      LINE_START <= tick & (hcnt_q == 12'h000);
      FRAME_START <= tick & (hcnt_q == 12'h000) & (vcnt_q == 11'h000);
      if (!en) begin
        div_q <= 3'b000;
        hcnt_q <= 12'h000;
        vcnt_q <= 11'h000;
        addr_q <= start_q[AW-1:0];
        base_q <= start_q[AW-1:0];
        lsub_q <= 3'b000;
        psub_q <= 3'b000;
      end else begin
        div_q <= tick ? div_lim : div_q - 3'b001;
      end
      if (tick) begin
        hcnt_q <= line_end ? 12'h000 : hcnt_q + 12'h001;
        if (line_end) begin
          vcnt_q <= frame_end ? 11'h000 : vcnt_q + 11'h001;
        end
        if (act) begin
          MEM_ADDR <= addr_q;
          if (rot) begin
            sh_q <= rsh[2:0];
            addr_q <= addr_q + stride_x;
          end else begin
            sh_q <= lsh[2:0];
            psub_q <= (psub_q == ppb_m1) ? 3'b000 : psub_q + 3'b001;
            if (psub_q == ppb_m1) begin
              addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
            end
          end
        end
        if (frame_end) begin
          frames_q <= frames_q + 8'h01;
          addr_q <= start_q[AW-1:0];
          base_q <= start_q[AW-1:0];
          lsub_q <= 3'b000;
          psub_q <= 3'b000;
        end else if (line_end && rot) begin
          if (lsub_q == ppb_m1) begin
            lsub_q <= 3'b000;
            base_q <= base_m1;
            addr_q <= base_m1;
          end else begin
            lsub_q <= lsub_q + 3'b001;
            addr_q <= base_q;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel extraction, look-up table and inversion
  wire [7:0] pix_idx = (MEM_DATA >> sh2_q) & pmask;
  wire [3:0] lut_g = lut_rd[7:4];
  wire [11:0] lut_px = mono ? {lut_g, lut_g, lut_g} : lut_rd;

  lut_mem #(
    .DW(12),
    .AW(8)
  ) u_lut (
    .clk(CLK),
    .we(wr_lut),
    .waddr(merged[`LUT_IDX_LO+7:`LUT_IDX_LO]),
    .wdata(merged[`LUT_DAT_LO+11:`LUT_DAT_LO]),
    .raddr(pix_idx),
    .rdata(lut_rd)
  );

  always @(posedge CLK) begin
    if (!RSTN) begin
      s2_v_q <= 1'b0;
      s3_v_q <= 1'b0;
      sh2_q <= 3'b000;
      PIX_VALID <= 1'b0;
      PIX_DATA <= 12'h000;
    end else begin
      s2_v_q <= MEM_RD;
      s3_v_q <= s2_v_q;
      sh2_q <= sh_q;
      PIX_VALID <= s3_v_q;
      if (s3_v_q) begin
        PIX_DATA <= invert ? ~lut_px : lut_px;
      end
    end
  end
endmodule

// [hdl/lcd_rot_defs.vh]
// Offsets, fields, masks and timing constants of the rotated refresh block
`ifndef LCD_ROT_DEFS_VH
`define LCD_ROT_DEFS_VH
`define OFS_CTRL 5'h00
`define OFS_HTIME 5'h04
`define OFS_VTIME 5'h08
`define OFS_START 5'h0c
`define OFS_STRIDE 5'h10
`define OFS_LUT 5'h14
`define OFS_STATUS 5'h18
`define OFS_FLEN 5'h1c
`define MASK_CTRL 32'h0000_3fc3
`define MASK_HTIME 32'h0000_1f7f
`define MASK_VTIME 32'h003f_03ff
`define MASK_START 32'h0001_ffff
`define MASK_STRIDE 32'h0000_00ff
`define MASK_LUT 32'h000f_ffff
`define RST_WORD 32'h0000_0000
`define CTRL_PSEL_LO 0
`define CTRL_ALT 6
`define CTRL_ROT 7
`define CTRL_INV 8
`define CTRL_MONO 9
`define CTRL_BPP_LO 10
`define CTRL_DUAL 12
`define CTRL_EN 13
`define HT_ACT_LO 0
`define HT_BLK_LO 8
`define VT_ACT_LO 0
`define VT_ACT_HI 8
`define VT_BLK_LO 16
`define LUT_IDX_LO 0
`define LUT_DAT_LO 8
`define H_ACT_ONE 8'h01
`define H_BLK_ADD 6'h04
`define V_ACT_ONE 11'h001
`define STRIDE_ZERO 9'h100
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [hdl/lut_mem.v]
// Colour look-up table memory with registered read data
`timescale 1ns/1ps
module lut_mem #(
  parameter DW = 12,
  parameter AW = 8
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// [testbench/rot_refresh_chk.sv]
// Port checker for the rotated refresh block
`timescale 1ns/1ps
module rot_refresh_chk (
  input wire CLK,
  input wire RSTN,
  input wire AWREADY,
  input wire WREADY,
  input wire BVALID,
  input wire BREADY,
  input wire ARVALID,
  input wire ARREADY,
  input wire RVALID,
  input wire RREADY,
  input wire MEM_RD,
  input wire PCLK_EN,
  input wire LINE_START,
  input wire FRAME_START,
  input wire PIX_VALID
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////
  // Pixel pipeline
  sequence s_pix;
    ##3 PIX_VALID;
  endsequence
  frame_line_a: assert property (FRAME_START |-> LINE_START)
    else $error("frame start without line start");
  pix_delay_a: assert property (MEM_RD |-> s_pix)
    else $error("pixel not three cycles after fetch");
  read_tick_a: assert property (MEM_RD |-> PCLK_EN)
    else $error("fetch off pixel clock tick");
  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  wr_busy_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  rd_busy_a: assert property (RVALID |-> !ARREADY)
    else $error("read taken while data pending");
  rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  r_drop_a: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read data held after handshake");
  b_drop_a: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write response held after handshake");
endmodule
bind rot_refresh_top rot_refresh_chk chk (.CLK(CLK), .RSTN(RSTN),
  .AWREADY(AWREADY), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
  .MEM_RD(MEM_RD), .PCLK_EN(PCLK_EN), .LINE_START(LINE_START),
  .FRAME_START(FRAME_START), .PIX_VALID(PIX_VALID));

// [testbench/panel_buf_model.sv]
// Display buffer model: byte equals low address byte
`timescale 1ns/1ps
module panel_buf_model (
  input wire clk,
  input wire rd,
  input wire [16:0] addr,
  output reg [7:0] data
);
  initial data = 8'h00;
  // Answers every cycle at full clock rate, garbage when idle
  always @(posedge clk) begin
    if (rd)
      data <= addr[7:0];
    else
      data <= ~data;
  end
endmodule

// [testbench/tb_top.sv]
// Testbench of the rotated refresh block
`timescale 1ns/1ps
`include "lcd_rot_defs.vh"
module tb_top;
  reg CLK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  reg [31:0] AWADDR, WDATA, ARADDR;
  reg [3:0] WSTRB;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, MEM_RD, PCLK_EN;
  wire LINE_START, FRAME_START, PIX_VALID;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire [16:0] MEM_ADDR;
  wire [7:0] MEM_DATA;
  wire [11:0] PIX_DATA;
  integer mismatches, checks, gap, i;
  reg [31:0] rd_q;
  reg [1:0] rsp_q;
  reg [16:0] a0, a1;
  reg [11:0] px;
  rot_refresh_top DUT (.CLK(CLK), .RSTN(RSTN), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
    .MEM_DATA(MEM_DATA), .PCLK_EN(PCLK_EN), .LINE_START(LINE_START),
    .FRAME_START(FRAME_START), .PIX_DATA(PIX_DATA), .PIX_VALID(PIX_VALID));
  panel_buf_model buf_m (.clk(CLK), .rd(MEM_RD), .addr(MEM_ADDR),
    .data(MEM_DATA));
  ////////////////////////////////////////////////////////////////////////////
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      if (mismatches == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    begin
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      @(posedge CLK);
      while (AWVALID || WVALID) begin
        if (AWREADY)
          AWVALID <= 1'b0;
        if (WREADY)
          WVALID <= 1'b0;
        @(posedge CLK);
      end
      while (!BVALID) @(posedge CLK);
      rsp_q = BRESP;
    end
  endtask
  task rd(input [31:0] a);
    begin
      ARADDR <= a;
      ARVALID <= 1'b1;
      @(posedge CLK);
      while (!ARREADY) @(posedge CLK);
      ARVALID <= 1'b0;
      @(posedge CLK);
      while (!RVALID) @(posedge CLK);
      rd_q = RDATA;
      rsp_q = RRESP;
    end
  endtask
  // Two fetch addresses, their spacing and the first pixel output once the second fetch is seen
  task grab;
    begin
      repeat (2) begin
        @(posedge CLK);
        while (!FRAME_START) @(posedge CLK);
      end
      while (!MEM_RD) @(posedge CLK);
      a0 = MEM_ADDR;
      gap = 1;
      @(posedge CLK);
      while (!MEM_RD) begin
        gap = gap + 1;
        @(posedge CLK);
      end
      a1 = MEM_ADDR;
      while (!PIX_VALID) @(posedge CLK);
      px = PIX_DATA;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    #500000;
    mismatches = mismatches + 1;
    conclude;
  end
  initial begin
    mismatches = 0;
    checks = 0;
    RSTN = 1'b0;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    ARVALID = 1'b0;
    BREADY = 1'b1;
    RREADY = 1'b1;
    AWADDR = 32'h0000_0000;
    WDATA = 32'h0000_0000;
    ARADDR = 32'h0000_0000;
    WSTRB = 4'hf;
    repeat (20) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (2) @(posedge CLK);
    for (i = 0; i < 7; i = i + 1) begin
      rd(i * 4);
      check(rd_q, `RST_WORD);
    end
    rd(`OFS_FLEN);
    check(rd_q, 32'h0000_0028);
    rd(32'h0000_0002);
    check(rsp_q, `RESP_SLVERR);
    wr(`OFS_HTIME, 32'hffff_ffff);
    check(rsp_q, `RESP_OKAY);
    rd(`OFS_HTIME);
    check(rd_q, `MASK_HTIME);
    rd(`OFS_FLEN);
    check(rd_q, 32'h0000_0518);
    wr(`OFS_HTIME, 32'h0000_0001);
    wr(`OFS_VTIME, 32'h0002_0103);
    rd(`OFS_FLEN);
    check(rd_q, 32'h0000_3120);
    wr(`OFS_CTRL, 32'h0000_1000);
    rd(`OFS_FLEN);
    check(rd_q, 32'h0000_3180);
    wr(`OFS_VTIME, 32'h0002_0003);
    wr(`OFS_LUT, 32'h000a_bc00);
    wr(`OFS_START, 32'h0000_0100);
    wr(`OFS_STRIDE, 32'h0000_0000);
    wr(`OFS_CTRL, 32'h0000_2d80);
    grab;
    check(a0, 17'h0_0100);
    check(a1, 17'h0_0200);
    check(gap, 1);
    check(px, 12'h543);
    while (!LINE_START || FRAME_START) @(posedge CLK);
    check(MEM_ADDR, 17'h0_00ff);
    rd(`OFS_STATUS);
    check(rd_q[18:17], 2'b01);
    wr(`OFS_START, 32'h0000_0300);
    wr(`OFS_CTRL, 32'h0000_2f80);
    grab;
    check(a0, 17'h0_0300);
    check(px, 12'h444);
    wr(`OFS_START, 32'h0000_0101);
    wr(`OFS_STRIDE, 32'h0000_0001);
    wr(`OFS_CTRL, 32'h0000_2d83);
    grab;
    check(a0, 17'h0_0101);
    check(a1, 17'h0_0102);
    check(gap, 8);
    wr(`OFS_START, 32'h0000_0100);
    wr(`OFS_STRIDE, 32'h0000_00a0);
    wr(`OFS_CTRL, 32'h0000_2dc0);
    grab;
    check(a1, 17'h0_01a0);
    check(gap, 2);
    rd(`OFS_STATUS);
    check(rd_q[18:17], 2'b11);
    wr(`OFS_CTRL, 32'h0000_2c03);
    grab;
    check(gap, 1);
    check(a1 - a0, 17'h0_0001);
    conclude;
  end
endmodule
